// ===== pbs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.svh"
// Operation
// - enable after on debounce plus trim
// - turn-off after off debounce plus trim
// - 512ms blanking ignores kill and button
// - kill low at blank end aborts
// - kill low releases enable when running
// - validated off press drives interrupt low
// - 1024ms delay, kill ends it early
// - delay expiry releases enable
// - 256ms button lockout after release
// - delay timed from interrupt fall only
// - enable polarity chosen by variant
// - button low restarts release debounce
// - debounce button release 32ms
// - reset releases enable and interrupt
module pbs_sequencer #(
  parameter int       TICK_CYC           = `PBS_TICK_CYC,
  parameter int       TURN_ON_DELAY_TRIM = 0,
  parameter int       TURN_OFF_DELAY_TRIM = 0,
  parameter bit       ENABLE_ACTIVE_LOW  = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic push_button_n,
  input  wire logic kill_n,
  output var  logic enable_out,
  output var  logic enable_oe,
  output var  logic int_n_out,
  output var  logic int_n_oe
);
  // -----------------------------------------------------------------
  // interval lengths in ticks, kill pulse width in clock cycles
  // -----------------------------------------------------------------
  localparam logic [15:0] ON_TICKS  =
    16'(`PBS_DEBOUNCE_MS + TURN_ON_DELAY_TRIM);
  localparam logic [15:0] OFF_TICKS =
    16'(`PBS_DEBOUNCE_MS + TURN_OFF_DELAY_TRIM);
  localparam logic [15:0] DB_TICKS    = 16'(`PBS_DEBOUNCE_MS);
  localparam logic [15:0] BLANK_TICKS = 16'(`PBS_BLANK_MS);
  localparam logic [15:0] OFFD_TICKS  = 16'(`PBS_OFF_DELAY_MS);
  localparam logic [15:0] LOCK_TICKS  = 16'(`PBS_LOCKOUT_MS);
  localparam logic [15:0] KPW_CYC     = 16'(`PBS_KILL_PW_CYC);

  pbs_pkg::pbs_state_t state_q;
  pbs_pkg::pbs_out_t   out_q;
  logic                tick;
  logic [1:0]          pb_sync_q;
  logic [1:0]          kill_sync_q;
  logic [15:0]         tcnt_q;
  logic [15:0]         kcnt_q;
  logic                kill_low_q;
  logic                pb_low;
  logic                tdone_on;
  logic                tdone_off;
  logic                tdone_db;

  // -----------------------------------------------------------------
  // shared timebase
  // -----------------------------------------------------------------
  pbs_timebase #(
    .TICK_CYC (TICK_CYC)
  ) u_tb (
    .mclk (mclk),
    .rst  (rst),
    .tick (tick)
  );

  // two flop synchronisers for the pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      pb_sync_q   <= 2'h3;
      kill_sync_q <= 2'h0;
    end else begin
      pb_sync_q   <= {pb_sync_q[0], push_button_n};
      kill_sync_q <= {kill_sync_q[0], kill_n};
    end
  end

  assign pb_low = ~pb_sync_q[1];

  // kill low qualified by minimum pulse width
  always_ff @(posedge mclk) begin
    if (rst) begin
      kcnt_q     <= 16'h0;
      kill_low_q <= 1'b0;
    end else if (kill_sync_q[1]) begin
      kcnt_q     <= 16'h0;
      kill_low_q <= 1'b0;
    end else if (kcnt_q >= KPW_CYC - 16'h1) begin
      kill_low_q <= 1'b1;
    end else begin
      kcnt_q <= kcnt_q + 16'h1;
    end
  end

  assign tdone_on  = tick && (tcnt_q >= ON_TICKS - 16'h1);
  assign tdone_off = tick && (tcnt_q >= OFF_TICKS - 16'h1);
  assign tdone_db  = tick && (tcnt_q >= DB_TICKS - 16'h1);

  // -----------------------------------------------------------------
  // sequencing state machine
  // -----------------------------------------------------------------
  // state and interval counter; counter clears on every transition except PBS_ON_DB to PBS_OFF and PBS_OFF_DB to PBS_RUN
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= pbs_pkg::PBS_OFF;
      tcnt_q  <= 16'h0;
    end else begin
      if (tick) begin
        tcnt_q <= tcnt_q + 16'h1;
      end
      unique case (state_q)
        pbs_pkg::PBS_OFF: begin
          tcnt_q <= 16'h0;
          if (pb_low) begin
            state_q <= pbs_pkg::PBS_ON_DB;
          end
        end
        pbs_pkg::PBS_ON_DB: begin
          if (!pb_low) begin
            state_q <= pbs_pkg::PBS_OFF;
          end else if (tdone_on) begin
            state_q <= pbs_pkg::PBS_BLANK;
            tcnt_q  <= 16'h0;
          end
        end
        pbs_pkg::PBS_BLANK: begin
          if (tick && tcnt_q >= BLANK_TICKS - 16'h1) begin
            tcnt_q <= 16'h0;
            if (!kill_sync_q[1]) begin
              state_q <= pbs_pkg::PBS_LOCK;
            end else begin
              state_q <= pbs_pkg::PBS_REL_DB;
            end
          end
        end
        pbs_pkg::PBS_REL_DB: begin
          if (kill_low_q) begin
            state_q <= pbs_pkg::PBS_LOCK;
            tcnt_q  <= 16'h0;
          end else if (pb_low) begin
            tcnt_q <= 16'h0;
          end else if (tdone_db) begin
            state_q <= pbs_pkg::PBS_RUN;
            tcnt_q  <= 16'h0;
          end
        end
        pbs_pkg::PBS_RUN: begin
          tcnt_q <= 16'h0;
          if (kill_low_q) begin
            state_q <= pbs_pkg::PBS_LOCK;
          end else if (pb_low) begin
            state_q <= pbs_pkg::PBS_OFF_DB;
          end
        end
        pbs_pkg::PBS_OFF_DB: begin
          if (kill_low_q) begin
            state_q <= pbs_pkg::PBS_LOCK;
            tcnt_q  <= 16'h0;
          end else if (!pb_low) begin
            state_q <= pbs_pkg::PBS_RUN;
          end else if (tdone_off) begin
            state_q <= pbs_pkg::PBS_OFF_WAIT;
            tcnt_q  <= 16'h0;
          end
        end
        pbs_pkg::PBS_OFF_WAIT: begin
          if (kill_low_q) begin
            state_q <= pbs_pkg::PBS_LOCK;
            tcnt_q  <= 16'h0;
          end else if (tick && tcnt_q >= OFFD_TICKS - 16'h1) begin
            state_q <= pbs_pkg::PBS_LOCK;
            tcnt_q  <= 16'h0;
          end
        end
        pbs_pkg::PBS_LOCK: begin
          // lockout, then release debounce before idle
          if (tcnt_q >= LOCK_TICKS && pb_low) begin
            tcnt_q <= LOCK_TICKS;
          end else if (tick &&
                       tcnt_q >= LOCK_TICKS + DB_TICKS - 16'h1) begin
            state_q <= pbs_pkg::PBS_OFF;
            tcnt_q  <= 16'h0;
          end
        end
      endcase
    end
  end

  // output intent registered from the current state
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      out_q.en_asserted  <= (state_q == pbs_pkg::PBS_BLANK) ||
                            (state_q == pbs_pkg::PBS_REL_DB) ||
                            (state_q == pbs_pkg::PBS_RUN) ||
                            (state_q == pbs_pkg::PBS_OFF_DB) ||
                            (state_q == pbs_pkg::PBS_OFF_WAIT);
      out_q.int_asserted <= (state_q == pbs_pkg::PBS_OFF_WAIT);
    end
  end

  // -----------------------------------------------------------------
  // open-drain pin drive
  // -----------------------------------------------------------------
  // sink enable only while pulling the pin low
  always_ff @(posedge mclk) begin
    if (rst) begin
      enable_out <= 1'b0;
      enable_oe  <= ~ENABLE_ACTIVE_LOW;
      int_n_out  <= 1'b0;
      int_n_oe   <= 1'b0;
    end else begin
      enable_out <= 1'b0;
      enable_oe  <= ENABLE_ACTIVE_LOW ? out_q.en_asserted
                                      : ~out_q.en_asserted;
      int_n_out  <= 1'b0;
      int_n_oe   <= out_q.int_asserted;
    end
  end
endmodule
`default_nettype wire

// ===== pbs_defines.svh
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH
// -----------------------------------------------------------------
// timebase and interval constants
// -----------------------------------------------------------------
`define PBS_CLK_HZ        100000000
`define PBS_TICK_US       1000
`define PBS_TICK_CYC      ((`PBS_CLK_HZ / 1000000) * `PBS_TICK_US)
`define PBS_DEBOUNCE_MS   32
`define PBS_BLANK_MS      512
`define PBS_OFF_DELAY_MS  1024
`define PBS_LOCKOUT_MS    256
`define PBS_KILL_PW_US    30
`define PBS_KILL_PW_CYC   ((`PBS_CLK_HZ / 1000000) * `PBS_KILL_PW_US)
`endif

// ===== pbs_pkg.sv
`default_nettype none
package pbs_pkg;
  typedef enum logic [2:0] {
    PBS_OFF, PBS_ON_DB, PBS_BLANK, PBS_REL_DB, PBS_RUN, PBS_OFF_DB,
    PBS_OFF_WAIT, PBS_LOCK
  } pbs_state_t;
  typedef struct packed {
    logic en_asserted;
    logic int_asserted;
  } pbs_out_t;
endpackage
`default_nettype wire

// ===== pbs_timebase.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.svh"
module pbs_timebase #(
  parameter int TICK_CYC = `PBS_TICK_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  output var  logic tick
);
  logic [31:0] cnt_q;
  // free running divider, one pulse per timebase period
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_q == 32'(TICK_CYC - 1)) begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== pbs_sequencer_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.svh"
module pbs_chk #(
  parameter int TICK_CYC            = `PBS_TICK_CYC,
  parameter int TURN_ON_DELAY_TRIM  = 0,
  parameter int TURN_OFF_DELAY_TRIM = 0,
  parameter bit ENABLE_ACTIVE_LOW   = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic push_button_n,
  input wire logic kill_n,
  input wire logic enable_out,
  input wire logic enable_oe,
  input wire logic int_n_out,
  input wire logic int_n_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // interval bounds in clock cycles, with slack for sync and pipeline
  localparam int DB_ON   = `PBS_DEBOUNCE_MS + TURN_ON_DELAY_TRIM;
  localparam int DB_OFF  = `PBS_DEBOUNCE_MS + TURN_OFF_DELAY_TRIM;
  localparam int ON_MIN  = (DB_ON - 1) * TICK_CYC;
  localparam int ON_MAX  = DB_ON * TICK_CYC + 30;
  localparam int OFF_PB  = (DB_OFF - 1) * TICK_CYC;
  localparam int GAP_MIN = (`PBS_LOCKOUT_MS + `PBS_DEBOUNCE_MS - 1) * TICK_CYC;
  localparam int BLK_MIN = (`PBS_BLANK_MS - 1) * TICK_CYC - 10;
  localparam int BLK_CHK = `PBS_BLANK_MS * TICK_CYC + 130;
  localparam int RUN_MIN = `PBS_BLANK_MS * TICK_CYC + 280;
  localparam int KPW     = `PBS_KILL_PW_CYC;
  localparam int KPW_MIN = `PBS_KILL_PW_CYC - 10;
  localparam int OFD_MIN = (`PBS_OFF_DELAY_MS - 1) * TICK_CYC - 10;
  localparam int OFD_MAX = `PBS_OFF_DELAY_MS * TICK_CYC + 40;
  logic        en;
  logic [31:0] on_q, off_q, pb_q, kl_q, it_q;
  logic        hi_q;
  // enable asserted level per variant
  assign en = ENABLE_ACTIVE_LOW ? enable_oe : !enable_oe;
  // interval counters, saturating where a level may last long
  always_ff @(posedge mclk) begin
    if (rst) begin
      on_q  <= 32'h0;
      off_q <= 32'hFFFFFFFF;
      pb_q  <= 32'h0;
      kl_q  <= 32'h0;
      it_q  <= 32'h0;
      hi_q  <= 1'b0;
    end else begin
      on_q  <= en ? on_q + 32'h1 : 32'h0;
      off_q <= (en && on_q > 32'h4) ? 32'h0 : off_q + {31'h0, ~&off_q};
      pb_q  <= push_button_n ? 32'h0 : pb_q + {31'h0, ~&pb_q};
      kl_q  <= kill_n ? 32'h0 : kl_q + {31'h0, ~&kl_q};
      it_q  <= int_n_oe ? it_q + 32'h1 : 32'h0;
      hi_q  <= en & (hi_q | kill_n);
    end
  end
  AST_ON_MIN: assert property ($rose(en) && !$past(rst) |->
    $past(pb_q) >= ON_MIN && $past(off_q) >= GAP_MIN)
    else $error("enable asserted too early");
  AST_ON_MAX: assert property ((pb_q == ON_MAX && &off_q && !en)
    |-> ##[0:10] en) else $error("enable not asserted");
  AST_BLANK_MIN: assert property ($fell(en) && $past(on_q) > 32'h10
    |-> $past(on_q) >= BLK_MIN) else $error("released in blanking");
  AST_ABORT: assert property ((en && on_q == BLK_CHK) |-> hi_q)
    else $error("power-up not aborted");
  AST_KILL: assert property ((kl_q == KPW && on_q > RUN_MIN)
    |-> ##[0:40] !en) else $error("kill did not release enable");
  AST_KILL_PW: assert property ($fell(en) && $past(on_q) > RUN_MIN
    && $past(it_q) < OFD_MIN - 20 |-> $past(kl_q) >= KPW_MIN)
    else $error("short kill released enable");
  AST_INT_EN: assert property ($rose(int_n_oe) |-> en && on_q > RUN_MIN)
    else $error("interrupt outside run");
  AST_INT_PB: assert property ($rose(int_n_oe) |->
    $past(pb_q) >= OFF_PB) else $error("interrupt without full press");
  AST_OFF_MAX: assert property (int_n_oe |-> it_q < OFD_MAX)
    else $error("off delay overran");
  AST_OFF_MIN: assert property ($fell(en) && $past(int_n_oe) &&
    kl_q == 32'h0 |-> $past(it_q) >= OFD_MIN)
    else $error("off delay too short");
  AST_ODRAIN: assert property (enable_out == 1'b0 && int_n_out == 1'b0)
    else $error("open-drain data not low");
  C_INT: cover property ($rose(int_n_oe));
  C_TMO: cover property ($fell(en) && $past(it_q) > OFD_MIN - 220);
  C_ABRT: cover property ($fell(en) && !hi_q && $past(on_q) > BLK_MIN - 100);
endmodule
bind pbs_sequencer pbs_chk #(
  .TICK_CYC            (TICK_CYC),
  .TURN_ON_DELAY_TRIM  (TURN_ON_DELAY_TRIM),
  .TURN_OFF_DELAY_TRIM (TURN_OFF_DELAY_TRIM),
  .ENABLE_ACTIVE_LOW   (ENABLE_ACTIVE_LOW)
) u_chk (
  .mclk(mclk), .rst(rst), .push_button_n(push_button_n), .kill_n(kill_n),
  .enable_out(enable_out), .enable_oe(enable_oe), .int_n_out(int_n_out),
  .int_n_oe(int_n_oe));
`default_nettype wire

// ===== pbs_cpu.sv
`timescale 1ns/1ps
`default_nettype none
module pbs_cpu (
  input  wire logic       mclk,
  input  wire logic       en_pin,
  input  wire logic       int_pin,
  input  wire logic [1:0] mode,
  input  wire logic       kill_cmd,
  output var  logic       kill_n
);
  logic [15:0] up_q, ir_q;
  logic        ack_q;
  // boot time, interrupt wait, shutdown done; mode 1 never boots, 2 ignores
  always_ff @(posedge mclk) begin
    up_q   <= !en_pin ? 16'h0 : up_q + {15'h0, up_q < 16'd2000};
    ir_q   <= int_pin ? 16'h0 : ir_q + {15'h0, ir_q < 16'd600};
    ack_q  <= en_pin & (ack_q | (ir_q == 16'd500 && mode != 2'h2));
    kill_n <= en_pin && up_q > 16'd1000 && mode != 2'h1
      && !ack_q && !kill_cmd;
  end
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       mclk, rst, pb_n, kill_cmd, en_oe, en_o, in_oe, in_o, kill_n;
  logic       en_pin, int_pin;
  logic       en2_oe, en2_o, in2_oe, in2_o, en2_pin;
  logic [1:0] mode;
  int         error_cnt, check_count;
  // pins with pull-ups
  assign en_pin  = !en_oe;
  assign int_pin = !in_oe;
  assign en2_pin = !en2_oe;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  pbs_sequencer #(.TICK_CYC(10)) DUT (.mclk(mclk), .rst(rst),
    .push_button_n(pb_n), .kill_n(kill_n), .enable_out(en_o),
    .enable_oe(en_oe), .int_n_out(in_o), .int_n_oe(in_oe));
  // low-true enable variant, same stimulus, mirrored pin level
  pbs_sequencer #(.TICK_CYC(10), .ENABLE_ACTIVE_LOW(1'b1)) DUT_LOW (
    .mclk(mclk), .rst(rst), .push_button_n(pb_n), .kill_n(kill_n),
    .enable_out(en2_o), .enable_oe(en2_oe), .int_n_out(in2_o),
    .int_n_oe(in2_oe));
  pbs_cpu u_cpu (.mclk(mclk), .en_pin(en_pin), .int_pin(int_pin),
    .mode(mode), .kill_cmd(kill_cmd), .kill_n(kill_n));
  task stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task check(string nm, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s exp %b got %b", nm, exp, got);
    end
  endtask
  task wait_en(logic v, int n);
    for (int i = 0; i < n && en_pin !== v; i++) @(posedge mclk);
    check("enable wait", v, en_pin);
    check("low variant enable", !en_pin, en2_pin);
    if (en_pin !== v) stop_test;
  endtask
  task press(int t);
    pb_n <= 1'b0;
    repeat (t * 10) @(posedge mclk);
    pb_n <= 1'b1;
    @(posedge mclk);
  endtask
  task idle(int t);
    repeat (t * 10) @(posedge mclk);
  endtask
  // short press refused, full press powers up, processor takes over
  task s_on;
    press(25);
    idle(20);
    check("short press", 1'b0, en_pin);
    press(40);
    check("power on", 1'b1, en_pin);
    idle(600);
    check("held on", 1'b1, en_pin);
  endtask
  // off press, processor answers, button refused in lockout
  task s_off;
    press(40);
    check("interrupt", 1'b0, int_pin);
    wait_en(1'b0, 5000);
    check("interrupt released", 1'b1, int_pin);
    press(300);
    check("lockout", 1'b0, en_pin);
    idle(50);
  endtask
  // processor ignores the interrupt
  task s_tmo;
    mode <= 2'h2;
    press(40);
    idle(600);
    press(40);
    idle(900);
    check("off delay hold", 1'b1, en_pin);
    wait_en(1'b0, 3000);
    idle(300);
  endtask
  // processor never raises kill
  task s_abort;
    mode <= 2'h1;
    press(40);
    idle(400);
    check("blank hold", 1'b1, en_pin);
    wait_en(1'b0, 2000);
    idle(300);
  endtask
  // short kill glitch ignored, long kill releases
  task s_kill;
    mode <= 2'h0;
    press(40);
    idle(600);
    kill_cmd <= 1'b1;
    repeat (200) @(posedge mclk);
    kill_cmd <= 1'b0;
    idle(1);
    check("kill glitch", 1'b1, en_pin);
    kill_cmd <= 1'b1;
    wait_en(1'b0, 4000);
    kill_cmd <= 1'b0;
    idle(300);
  endtask
  initial begin
    error_cnt   = 0;
    check_count = 0;
    rst         = 1'b1;
    pb_n        = 1'b1;
    kill_cmd    = 1'b0;
    mode        = 2'h0;
    repeat (5) @(posedge mclk);
    check("reset hold enable", 1'b0, en_pin);
    check("reset hold variant", 1'b1, en2_pin);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check("reset enable", 1'b0, en_pin);
    check("reset variant", 1'b1, en2_pin);
    check("reset interrupt", 1'b1, int_pin);
    s_on;
    s_off;
    s_tmo;
    s_abort;
    s_kill;
    stop_test;
  end
endmodule
`default_nettype wire
